// [rtl/mts_consts.svh]
// register offsets, reset values, source select, mode and response codes of the threshold switch
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH
`define MTS_ADDR_W          4
`define MTS_OFF_CTRL        4'h0
`define MTS_OFF_THR         4'h4
`define MTS_OFF_AXIS_HI     4'h8
`define MTS_OFF_STATUS      4'hc
`define MTS_CTRL_RST        32'h0000_0000
`define MTS_THR_RST         32'h0000_0000
`define MTS_AXIS_HI_RST     32'h0000_0000
`define MTS_SEL_ANGLE       2'h1
`define MTS_SEL_AXIS_HI     2'h2
`define MTS_SEL_MAG         2'h3
`define MTS_MODE_SWITCH     3'h5
`define MTS_MODE_OMNI       3'h6
`define MTS_RESP_OKAY       2'h0
`define MTS_RESP_SLVERR     2'h2
`define MTS_ZERO8           8'h00
`endif

// [rtl/mts_pkg.sv]
// types of the magnetic threshold switch
package mts_pkg;
  // one completed conversion: axis codes, angle and magnitude per axis pair
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
    logic [2:0][8:0]    angle_deg;
    logic [2:0][7:0]    magnitude;
  } mts_meas_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] angle_pair_select;
    logic [2:0] channel_enable;
    logic [2:0] int_mode;
    logic [1:0] threshold_source_select;
  } mts_ctrl_t;

  typedef struct packed {
    logic [7:0] angle_hysteresis;
    logic [7:0] second_threshold_config;
    logic [7:0] first_threshold_config;
  } mts_thr_t;

  typedef struct packed {
    logic signed [7:0] z;
    logic signed [7:0] y;
    logic signed [7:0] x;
  } mts_axis_hi_t;
endpackage

// [rtl/mts_switch.sv]
// threshold switch with axi4-lite register slave driving the active-low interrupt level
// Functional notes
// - source select 2h takes x, y, z upper limits from axis-limit registers.
// - each enabled axis compares against its own upper limit independently.
// - only enabled channels contribute to the tamper decision.
// - omnipolar mode ignores threshold sign bit, compares magnitudes.
// - angle switch uses angle of the axis pair selected.
// - output mode 5h with angle source gives an angle switch.
// - first threshold is angle reference, second is band width.
// - angle switch turns on when angle leaves band around reference.
// - angle switch turns off only after angle re-enters past hysteresis.
// - magnitude comes from the selected axis pair for button press.
// - source select 3h chooses magnitude threshold comparison.
// - magnitude source with output mode 5h gives a magnitude switch.
// - magnitude switch is not offered in omnipolar mode 6h.
// - magnitude switch on above high limit, off below low limit.
// - low magnitude limit is first threshold, high is second.
// - axis thresholds are signed 8-bit two's complement codes.
// - magnitude thresholds are unsigned 8-bit values 0 to 255.
// - reference weighs 2 degrees per step, band 1 degree per step.
// - a zero threshold disables its own comparison, limits independent.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mts_consts.svh"
module mts_switch #(
  parameter int MEAS_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [`MTS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [`MTS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              meas_valid,
  input  wire mts_pkg::mts_meas_t meas,
  output logic                   int_n
);
  import mts_pkg::*;

  // measurement struct is fixed at 16-bit axes
  if (MEAS_W != 16)
  begin : g_bad_meas_w
    $error("mts_switch: MEAS_W must match the 16-bit measurement struct");
  end

  // byte-lane merge shared by all writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] abs8(input logic signed [7:0] v);
    return v[7] ? 8'(-v) : v;
  endfunction

  logic [31:0]  ctrl_q,  next_ctrl_q;
  logic [31:0]  thr_q,   next_thr_q;
  logic [31:0]  axis_q,  next_axis_q;
  logic         aw_held, next_aw_held;
  logic         w_held,  next_w_held;
  logic [`MTS_ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [31:0]  wdata_q, next_wdata_q;
  logic [3:0]   wstrb_q, next_wstrb_q;
  logic         bvalid,  next_bvalid;
  logic [1:0]   bresp,   next_bresp;
  logic         rvalid,  next_rvalid;
  logic [1:0]   rresp,   next_rresp;
  logic [31:0]  rdata,   next_rdata;
  logic         sw_on,   next_sw_on;
  logic [2:0]   over_q,  next_over_q;

  mts_ctrl_t    ctrl;
  mts_thr_t     thr;
  mts_axis_hi_t axis_hi;

  assign ctrl    = mts_ctrl_t'(ctrl_q[15:0]);
  assign thr     = mts_thr_t'(thr_q[23:0]);
  assign axis_hi = mts_axis_hi_t'(axis_q[23:0]);

  // handshake outputs combinational, data from flops
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  // register bus
  always_comb
  begin
    logic [`MTS_ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        ha, hw;
    wa = aw_held ? awaddr_q : s_axi_awaddr;
    wd = w_held ? wdata_q : s_axi_wdata;
    ws = w_held ? wstrb_q : s_axi_wstrb;
    ha = aw_held || (s_axi_awvalid && s_axi_awready);
    hw = w_held || (s_axi_wvalid && s_axi_wready);
    next_ctrl_q   = ctrl_q;
    next_thr_q    = thr_q;
    next_axis_q   = axis_q;
    next_awaddr_q = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
    next_wdata_q  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
    next_wstrb_q  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
    next_aw_held  = ha;
    next_w_held   = hw;
    next_bvalid   = bvalid && !s_axi_bready;
    next_bresp    = bresp;
    if (ha && hw)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `MTS_RESP_OKAY;
      if (wa == `MTS_OFF_CTRL)
      begin
        next_ctrl_q = merge(ctrl_q, wd, ws) & 32'h0000_03ff;
      end
      else if (wa == `MTS_OFF_THR)
      begin
        next_thr_q = merge(thr_q, wd, ws) & 32'h00ff_ffff;
      end
      else if (wa == `MTS_OFF_AXIS_HI)
      begin
        next_axis_q = merge(axis_q, wd, ws) & 32'h00ff_ffff;
      end
      else if (wa == `MTS_OFF_STATUS)
      begin
        next_bresp = `MTS_RESP_OKAY;
      end
      else
      begin
        next_bresp = `MTS_RESP_SLVERR;
      end
    end
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `MTS_RESP_OKAY;
      if (s_axi_araddr == `MTS_OFF_CTRL)
      begin
        next_rdata = ctrl_q;
      end
      else if (s_axi_araddr == `MTS_OFF_THR)
      begin
        next_rdata = thr_q;
      end
      else if (s_axi_araddr == `MTS_OFF_AXIS_HI)
      begin
        next_rdata = axis_q;
      end
      else if (s_axi_araddr == `MTS_OFF_STATUS)
      begin
        next_rdata = {28'h000_0000, over_q, sw_on};
      end
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = `MTS_RESP_SLVERR;
      end
    end
  end

  // switch decision
  always_comb
  begin
    logic signed [7:0]  code [3];
    logic signed [7:0]  lim  [3];
    logic [2:0]         over;
    logic [8:0]         ang;
    logic [7:0]         mag;
    logic signed [11:0] a, up, lo;
    logic signed [11:0] hys;
    code[0] = meas.x[15:8];
    code[1] = meas.y[15:8];
    code[2] = meas.z[15:8];
    lim[0] = axis_hi.x;
    lim[1] = axis_hi.y;
    lim[2] = axis_hi.z;
    over = 3'h0;
    next_sw_on  = sw_on;
    next_over_q = over_q;
    ang = (ctrl.angle_pair_select < 2'h3) ? meas.angle_deg[ctrl.angle_pair_select] : 9'h000;
    mag = (ctrl.angle_pair_select < 2'h3) ? meas.magnitude[ctrl.angle_pair_select] : 8'h00;
    // reference 2 deg, band 1 deg
    a   = 12'(ang);
    up  = 12'({thr.first_threshold_config, 1'b0}) + 12'(thr.second_threshold_config);
    lo  = 12'({thr.first_threshold_config, 1'b0}) - 12'(thr.second_threshold_config);
    hys = 12'(thr.angle_hysteresis);
    for (int i = 0; i < 3; i++)
    begin
      if (ctrl.channel_enable[i] && lim[i] != `MTS_ZERO8)
      begin
        if (ctrl.int_mode == `MTS_MODE_OMNI)
        begin
          over[i] = abs8(code[i]) >= {1'b0, lim[i][6:0]};
        end
        else if (lim[i][7])
        begin
          over[i] = code[i] <= lim[i];
        end
        else
        begin
          over[i] = code[i] >= lim[i];
        end
      end
    end
    if (meas_valid)
    begin
      next_sw_on = 1'b0;
      next_over_q = 3'h0;
      if (ctrl.threshold_source_select == `MTS_SEL_AXIS_HI &&
          (ctrl.int_mode == `MTS_MODE_SWITCH || ctrl.int_mode == `MTS_MODE_OMNI))
      begin
        next_over_q = over;
        next_sw_on  = |over;
      end
      else if (ctrl.threshold_source_select == `MTS_SEL_ANGLE &&
               ctrl.int_mode == `MTS_MODE_SWITCH)
      begin
        next_sw_on = sw_on;
        if (thr.second_threshold_config != `MTS_ZERO8)
        begin
          if (a > up || a < lo)
          begin
            next_sw_on = 1'b1;
          end
          // back inside by hysteresis turns off
          else if (a <= up - hys && a >= lo + hys)
          begin
            next_sw_on = 1'b0;
          end
        end
        else
        begin
          next_sw_on = 1'b0;
        end
      end
      else if (ctrl.threshold_source_select == `MTS_SEL_MAG &&
               ctrl.int_mode == `MTS_MODE_SWITCH)
      begin
        next_sw_on = sw_on;
        if (thr.second_threshold_config != `MTS_ZERO8 &&
            mag > thr.second_threshold_config)
        begin
          next_sw_on = 1'b1;
        end
        else if (thr.first_threshold_config != `MTS_ZERO8 &&
                 mag < thr.first_threshold_config)
        begin
          next_sw_on = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= `MTS_CTRL_RST;
      thr_q    <= `MTS_THR_RST;
      axis_q   <= `MTS_AXIS_HI_RST;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `MTS_RESP_OKAY;
      rvalid   <= 1'b0;
      rresp    <= `MTS_RESP_OKAY;
      rdata    <= 32'h0000_0000;
      sw_on    <= 1'b0;
      over_q   <= 3'h0;
      int_n    <= 1'b1;
    end
    else
    begin
      ctrl_q   <= next_ctrl_q;
      thr_q    <= next_thr_q;
      axis_q   <= next_axis_q;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q  <= next_wdata_q;
      wstrb_q  <= next_wstrb_q;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rvalid   <= next_rvalid;
      rresp    <= next_rresp;
      rdata    <= next_rdata;
      sw_on    <= next_sw_on;
      over_q   <= next_over_q;
      int_n    <= !next_sw_on;
    end
  end
endmodule // mts_switch
`default_nettype wire

// [testbench/mts_switch_assertions.sv]
// checker of the switch level against measurements and shadowed settings
`timescale 1ns/1ps
`default_nettype none
`include "mts_consts.svh"
module mts_switch_checker (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [`MTS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   meas_valid,
  input wire mts_pkg::mts_meas_t     meas,
  input wire logic                   int_n
);
  import mts_pkg::*;
  mts_ctrl_t  ctl;
  mts_thr_t   thr;
  mts_axis_hi_t axh;
  logic [9:0] ang;
  logic [9:0] rf;
  logic [9:0] bd;
  logic [9:0] hy;
  logic [7:0] mg;
  logic       wr;
  logic       sw;
  logic       mag;
  logic       agl;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign sw = meas_valid && (ctl.int_mode == `MTS_MODE_SWITCH);
  assign mag = sw && (ctl.threshold_source_select == `MTS_SEL_MAG);
  assign agl = sw && (ctl.threshold_source_select == `MTS_SEL_ANGLE) && (bd != 10'h000);
  assign ang = (ctl.angle_pair_select == 2'h3) ? 10'h000 : 10'(meas.angle_deg[ctl.angle_pair_select]);
  assign mg = (ctl.angle_pair_select == 2'h3) ? 8'h00 : meas.magnitude[ctl.angle_pair_select];
  assign rf = {1'b0, thr.first_threshold_config, 1'b0};
  assign bd = {2'h0, thr.second_threshold_config};
  assign hy = {2'h0, thr.angle_hysteresis};
  // only the ports are visible, so settings are shadowed from byte-lane writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl <= '0;
      thr <= '0;
      axh <= '0;
    end
    else if (wr)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (s_axi_wstrb[i] && s_axi_awaddr == `MTS_OFF_CTRL)
        begin
          ctl[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
        end
      end
      for (int i = 0; i < 3; i++)
      begin
        if (s_axi_wstrb[i] && s_axi_awaddr == `MTS_OFF_THR)
        begin
          thr[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
        end
        if (s_axi_wstrb[i] && s_axi_awaddr == `MTS_OFF_AXIS_HI)
        begin
          axh[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
        end
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_level_hold: assert property (!meas_valid |=> $stable(int_n))
    else $error("switch level moved without a conversion");
  a_mag_on: assert property (mag && bd != 10'h000 && {2'h0, mg} > bd |=> !int_n)
    else $error("magnitude above high limit left switch off");
  a_mag_off: assert property (mag && !(bd != 10'h000 && {2'h0, mg} > bd)
    && rf != 10'h000 && {1'b0, mg, 1'b0} < rf |=> int_n)
    else $error("magnitude below low limit left switch on");
  a_mag_omni: assert property (meas_valid && ctl.int_mode == `MTS_MODE_OMNI
    && ctl.threshold_source_select == `MTS_SEL_MAG |=> int_n)
    else $error("magnitude switch active in omnipolar mode");
  a_angle_on: assert property (agl && (ang > rf + bd || ang + bd < rf) |=> !int_n)
    else $error("angle outside band left switch off");
  a_angle_off: assert property (agl && ang + bd >= rf + hy && ang + hy <= rf + bd |=> int_n)
    else $error("angle inside hysteresis left switch on");
  a_no_source: assert property (meas_valid && ctl.threshold_source_select == 2'h0 |=> int_n)
    else $error("switch on without a threshold source");
  a_write_resp: assert property (wr |=> s_axi_bvalid)
    else $error("write response missing");
  a_tamper_x: assert property (meas_valid && ctl.int_mode == `MTS_MODE_SWITCH
    && ctl.threshold_source_select == `MTS_SEL_AXIS_HI && ctl.channel_enable[0]
    && axh.x > 8'sh00 && $signed(meas.x[15:8]) >= axh.x |=> !int_n)
    else $error("x axis above its upper limit left switch off");
endmodule // mts_switch_checker
bind mts_switch mts_switch_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .meas_valid,
  .meas, .int_n);
`default_nettype wire

// [testbench/mts_host_model.sv]
// host side that watches the interrupt level
`timescale 1ns/1ps
`default_nettype none
module mts_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic int_n,
  output logic     switch_seen
);
  logic next_switch_seen;
  always_comb next_switch_seen = aresetn ? !int_n : 1'b0;
  always_ff @(posedge aclk) switch_seen <= next_switch_seen;
endmodule // mts_host_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the threshold switch
`timescale 1ns/1ps
`default_nettype none
`include "mts_consts.svh"
module testbench;
  import mts_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, meas_valid = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_b;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        int_n, seen;
  mts_meas_t   meas = '0;
  int          mismatches = 0, cmp_count = 0;
  always #25 aclk = ~aclk;
  mts_switch DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .meas_valid, .meas, .int_n);
  mts_host_model host (.aclk, .aresetn, .int_n, .switch_seen(seen));
  task automatic give_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        wr_b = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    // a lost response ends the run as a failure
    if (n == 40)
    begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40)
    begin
      mismatches++;
      give_verdict;
    end
  endtask
  // one conversion, then the level as seen at the pin and by the host
  task automatic conv(input logic [15:0] x, input logic [8:0] ang, input logic [7:0] mg,
                      input logic on);
    mts_meas_t m;
    m = '0;
    m.x = x;
    m.angle_deg = {9'h05a, ang, 9'h05a};
    m.magnitude = {mg, 16'h0000};
    @(posedge aclk);
    meas <= m;
    meas_valid <= 1'b1;
    @(posedge aclk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("switch", {int_n, seen}, {!on, on});
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MTS_OFF_CTRL);
    chk("ctrl", rd_d, `MTS_CTRL_RST);
    rd(4'h2);
    chk("resp", rd_r, `MTS_RESP_SLVERR);
    conv(16'h7f00, 9'h000, 8'hff, 1'b0);
    wr(`MTS_OFF_CTRL, 32'hf6);
    chk("bresp", wr_b, `MTS_RESP_OKAY);
    wr(`MTS_OFF_AXIS_HI, 32'h202020);
    conv(16'h3000, 9'h000, 8'h00, 1'b1);
    rd(`MTS_OFF_STATUS);
    chk("status", rd_d, 32'h0000_0003);
    conv(16'h1000, 9'h000, 8'h00, 1'b0);
    wr(`MTS_OFF_CTRL, 32'hd6);
    conv(16'h7f00, 9'h000, 8'h00, 1'b0);
    wr(`MTS_OFF_CTRL, 32'hfa);
    wr(`MTS_OFF_AXIS_HI, 32'ha0a0a0);
    conv(16'hd000, 9'h000, 8'h00, 1'b1);
    conv(16'h1000, 9'h000, 8'h00, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h1f5);
    wr(`MTS_OFF_THR, 32'h030a2d);
    conv(16'h0000, 9'h069, 8'h00, 1'b1);
    conv(16'h0000, 9'h062, 8'h00, 1'b1);
    conv(16'h0000, 9'h060, 8'h00, 1'b0);
    conv(16'h0000, 9'h04f, 8'h00, 1'b1);
    // mid-run reset while the switch is on
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset", {int_n, seen}, 32'h0000_0002);
    rd(`MTS_OFF_THR);
    chk("thr", rd_d, `MTS_THR_RST);
    wr(`MTS_OFF_CTRL, 32'h1f5);
    wr(`MTS_OFF_THR, 32'h0000_002d);
    conv(16'h0000, 9'h04f, 8'h00, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h2f7);
    wr(`MTS_OFF_THR, 32'h00c040);
    conv(16'h0000, 9'h000, 8'hd0, 1'b1);
    conv(16'h0000, 9'h000, 8'h80, 1'b1);
    conv(16'h0000, 9'h000, 8'h30, 1'b0);
    // only the high-limit byte lane is written
    s_axi_wstrb <= 4'h2;
    wr(`MTS_OFF_THR, 32'h0000_8000);
    s_axi_wstrb <= 4'hf;
    rd(`MTS_OFF_THR);
    chk("thr", rd_d, 32'h0000_8040);
    conv(16'h0000, 9'h000, 8'ha0, 1'b1);
    conv(16'h0000, 9'h000, 8'hff, 1'b1);
    wr(`MTS_OFF_CTRL, 32'h2fb);
    chk("held", int_n, 1'b0);
    conv(16'h0000, 9'h000, 8'hff, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h2f7);
    wr(`MTS_OFF_THR, 32'h000040);
    conv(16'h0000, 9'h000, 8'hff, 1'b0);
    wr(4'h2, 32'hffff_ffff);
    chk("bresp", wr_b, `MTS_RESP_SLVERR);
    rd(`MTS_OFF_CTRL);
    chk("ctrl", rd_d, 32'h2f7);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
